/* File: eeprom_access_pkg.sv */
package eeprom_access_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int DEPTH = 64;
	localparam int PADDR_W = 8;
	localparam int TIMER_W = 16;

	// register byte offsets
	localparam logic [7:0] OFS_EE_ADDRESS = 8'h00;
	localparam logic [7:0] OFS_EE_DATA = 8'h04;
	localparam logic [7:0] OFS_PTR_ONE_HIGH = 8'h08;
	localparam logic [7:0] OFS_PTR_TWO_HIGH = 8'h0c;
	localparam logic [7:0] OFS_PTR_ONE_LOW = 8'h10;
	localparam logic [7:0] OFS_PTR_TWO_LOW = 8'h14;
	localparam logic [7:0] OFS_INDIRECT_ONE = 8'h18;
	localparam logic [7:0] OFS_INDIRECT_TWO = 8'h1c;
	localparam logic [7:0] OFS_IRQ_CTRL = 8'h20;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h28;

	// control register fields
	localparam int CTRL_RD_BIT = 0;
	localparam int CTRL_READ_ARM_BIT_BIT = 1;
	localparam int CTRL_WR_BIT = 2;
	localparam int CTRL_WRITE_ARM_BIT_BIT = 3;

	// indirect location of the control register
	localparam logic [7:0] CTRL_SECTOR = 8'h01;
	localparam logic [7:0] CTRL_LOW_ADDR = 8'h40;
	localparam logic [7:0] POINTER_HIGH_POR = 8'h00;

	// status and mask layout
	localparam int IRQ_W = 3;
	localparam int ST_EE_BIT = 0;
	localparam int ST_MF_BIT = 1;
	localparam int ST_FAIL_BIT = 2;
	localparam int GLOBAL_EN_BIT = 0;

	// write cycle timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int WRITE_TIME_NS = 4000;
	localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum {st_idle, st_read, st_write, st_write_sync} op_state_t;

	typedef enum {
		sel_ee_address, sel_ee_data, sel_ptr_one_high, sel_ptr_two_high,
		sel_ptr_one_low, sel_ptr_two_low, sel_ind_one, sel_ind_two,
		sel_irq_ctrl, sel_irq_status, sel_irq_mask, sel_none
	} reg_sel_t;
endpackage : eeprom_access_pkg

/* File: eeprom_mem_if.sv */
`timescale 1ns/1ps
interface eeprom_mem_if;
	import eeprom_access_pkg::*;
	logic we;
	logic re;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	modport ctrl (output we, output re, output addr, output wdata, input rdata);
	modport array (input we, input re, input addr, input wdata, output rdata);
endinterface : eeprom_mem_if

/* File: eeprom_array.sv */
`timescale 1ns/1ps
module eeprom_array
	import eeprom_access_pkg::*;
(
	input wire logic pclk, // system clock
	eeprom_mem_if.array mem // array port
);
	logic [DATA_W-1:0] cells [DEPTH];
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] next_rdata;

	always_comb begin
		next_rdata = rdata_q;
		if (mem.re) begin
			next_rdata = cells[mem.addr];
		end
	end

	always_ff @(posedge pclk) begin
		if (mem.we) begin
			cells[mem.addr] <= mem.wdata;
		end
		rdata_q <= next_rdata;
	end

	assign mem.rdata = rdata_q;
endmodule : eeprom_array

/* File: eeprom_access_control.sv */
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
//
// Operation
// - Reset clears the write-arm bit so no write can start until software sets it.
// - Reset clears both pointer high bytes, so the control register in sector 1 is unreachable.
// - A finished write cycle sets the EEPROM request flag and the multi-function request flag.
// - The vector request rises only with global, EEPROM and multi-function enables set and stack not full.
// - Servicing clears only the multi-function flag; the EEPROM flag waits for software.
// - An operation still running when the core halts fails and is abandoned.
// - The write trigger acts only when write-arm was already set, and clears when the write ends.
// - A read starts only with read-arm set, clears its trigger at the end, and the data register holds the byte.
// - The control register is reached only indirectly, at low address 40h of sector 1.
module eeprom_access_control
	import eeprom_access_pkg::*;
#(
	parameter int WRITE_LEN = WRITE_CYCLES
) (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [PADDR_W-1:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic cpu_halt, // core entering idle or sleep
	input wire logic stack_full, // return stack full
	input wire logic irq_serviced, // pulse: interrupt vector taken
	output logic irq, // level interrupt
	output logic mf_vector_request, // branch to multi-function vector
	output logic busy // read or write in progress
);
	op_state_t state, next_state;
	logic [ADDR_W-1:0] ee_address_reg, next_ee_address_reg;
	logic [DATA_W-1:0] ee_data_reg, next_ee_data_reg;
	logic [7:0] pointer_one_high_byte, next_pointer_one_high_byte;
	logic [7:0] pointer_two_high_byte, next_pointer_two_high_byte;
	logic [7:0] pointer_one_low_byte, next_pointer_one_low_byte;
	logic [7:0] pointer_two_low_byte, next_pointer_two_low_byte;
	logic write_arm_bit, next_write_arm_bit;
	logic write_trigger, next_write_trigger;
	logic read_arm_bit, next_read_arm_bit;
	logic read_trigger, next_read_trigger;
	logic global_irq_enable, next_global_irq_enable;
	logic [IRQ_W-1:0] irq_mask, next_irq_mask;
	logic [IRQ_W-1:0] irq_status, next_irq_status;
	logic [TIMER_W-1:0] timer, next_timer;
	logic timer_done, next_timer_done;
	logic done_meta, done_sync;
	logic [ADDR_W-1:0] wr_addr, next_wr_addr;
	logic [DATA_W-1:0] wr_data, next_wr_data;
	logic ready_q, next_ready_q;
	logic [31:0] prdata_q, next_prdata_q;
	logic slverr_q, next_slverr_q;

	reg_sel_t sel;
	logic commit, bus_wr, ctrl_wr, start_wr, start_rd, commit_wr;
	logic [IRQ_W-1:0] irq_set, irq_clr;
	logic [7:0] ctrl_byte;

	eeprom_mem_if mem ();

	eeprom_array u_array (
		.pclk(pclk),
		.mem(mem)
	);

	function automatic reg_sel_t decode(input logic [PADDR_W-1:0] a);
		case (a)
			OFS_EE_ADDRESS: decode = sel_ee_address;
			OFS_EE_DATA: decode = sel_ee_data;
			OFS_PTR_ONE_HIGH: decode = sel_ptr_one_high;
			OFS_PTR_TWO_HIGH: decode = sel_ptr_two_high;
			OFS_PTR_ONE_LOW: decode = sel_ptr_one_low;
			OFS_PTR_TWO_LOW: decode = sel_ptr_two_low;
			OFS_INDIRECT_ONE: decode = sel_ind_one;
			OFS_INDIRECT_TWO: decode = sel_ind_two;
			OFS_IRQ_CTRL: decode = sel_irq_ctrl;
			OFS_IRQ_STATUS: decode = sel_irq_status;
			OFS_IRQ_MASK: decode = sel_irq_mask;
			default: decode = sel_none;
		endcase
	endfunction : decode

	function automatic logic points_at_ctrl(input logic [7:0] hi, input logic [7:0] lo);
		points_at_ctrl = (hi == CTRL_SECTOR) && (lo == CTRL_LOW_ADDR);
	endfunction : points_at_ctrl

	assign sel = decode(paddr);
	assign commit = psel && penable && ready_q;
	assign bus_wr = commit && pwrite;
	assign ctrl_byte = {4'h0, write_arm_bit, write_trigger, read_arm_bit, read_trigger};
	assign ctrl_wr = bus_wr && (((sel == sel_ind_one) &&
		points_at_ctrl(pointer_one_high_byte, pointer_one_low_byte)) ||
		((sel == sel_ind_two) &&
		points_at_ctrl(pointer_two_high_byte, pointer_two_low_byte)));
	// trigger needs the arm bit as it stood before this write
	assign start_wr = ctrl_wr && pwdata[CTRL_WR_BIT] && write_arm_bit &&
		(state == st_idle) && !cpu_halt;
	assign start_rd = ctrl_wr && pwdata[CTRL_RD_BIT] && read_arm_bit &&
		!pwdata[CTRL_WR_BIT] && (state == st_idle) && !cpu_halt;
	assign commit_wr = (state == st_write_sync) && done_sync && !cpu_halt;

	assign mem.we = commit_wr;
	assign mem.re = start_rd;
	assign mem.addr = commit_wr ? wr_addr : ee_address_reg;
	assign mem.wdata = wr_data;

	// apb read path and ready
	always_comb begin
		next_ready_q = psel && penable && !ready_q;
		next_prdata_q = prdata_q;
		next_slverr_q = 1'b0;
		if (psel && penable && !ready_q) begin
			next_prdata_q = 32'h0000_0000;
			next_slverr_q = (sel == sel_none);
			case (sel)
				sel_ee_address: next_prdata_q = {26'h0, ee_address_reg};
				sel_ee_data: next_prdata_q = {24'h0, ee_data_reg};
				sel_ptr_one_high: next_prdata_q = {24'h0, pointer_one_high_byte};
				sel_ptr_two_high: next_prdata_q = {24'h0, pointer_two_high_byte};
				sel_ptr_one_low: next_prdata_q = {24'h0, pointer_one_low_byte};
				sel_ptr_two_low: next_prdata_q = {24'h0, pointer_two_low_byte};
				sel_ind_one: begin
					if (points_at_ctrl(pointer_one_high_byte, pointer_one_low_byte)) begin
						next_prdata_q = {24'h0, ctrl_byte};
					end
				end
				sel_ind_two: begin
					if (points_at_ctrl(pointer_two_high_byte, pointer_two_low_byte)) begin
						next_prdata_q = {24'h0, ctrl_byte};
					end
				end
				sel_irq_ctrl: next_prdata_q = {31'h0, global_irq_enable};
				sel_irq_status: next_prdata_q = {29'h0, irq_status};
				sel_irq_mask: next_prdata_q = {29'h0, irq_mask};
				default: next_prdata_q = 32'h0000_0000;
			endcase
		end
	end

	// plain software registers
	always_comb begin
		next_ee_address_reg = ee_address_reg;
		next_pointer_one_high_byte = pointer_one_high_byte;
		next_pointer_two_high_byte = pointer_two_high_byte;
		next_pointer_one_low_byte = pointer_one_low_byte;
		next_pointer_two_low_byte = pointer_two_low_byte;
		next_global_irq_enable = global_irq_enable;
		next_irq_mask = irq_mask;
		if (bus_wr) begin
			case (sel)
				sel_ee_address: next_ee_address_reg = pwdata[ADDR_W-1:0];
				sel_ptr_one_high: next_pointer_one_high_byte = pwdata[7:0];
				sel_ptr_two_high: next_pointer_two_high_byte = pwdata[7:0];
				sel_ptr_one_low: next_pointer_one_low_byte = pwdata[7:0];
				sel_ptr_two_low: next_pointer_two_low_byte = pwdata[7:0];
				sel_irq_ctrl: next_global_irq_enable = pwdata[GLOBAL_EN_BIT];
				sel_irq_mask: next_irq_mask = pwdata[IRQ_W-1:0];
				default: next_ee_address_reg = ee_address_reg;
			endcase
		end
	end

	// control bits, operation sequencing and write timer
	always_comb begin
		next_state = state;
		next_write_arm_bit = write_arm_bit;
		next_read_arm_bit = read_arm_bit;
		next_write_trigger = write_trigger;
		next_read_trigger = read_trigger;
		next_ee_data_reg = ee_data_reg;
		next_timer = timer;
		next_timer_done = 1'b0;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		irq_set = '0;
		if (bus_wr && (sel == sel_ee_data)) begin
			next_ee_data_reg = pwdata[DATA_W-1:0];
		end
		if (ctrl_wr) begin
			next_write_arm_bit = pwdata[CTRL_WRITE_ARM_BIT_BIT];
			next_read_arm_bit = pwdata[CTRL_READ_ARM_BIT_BIT];
		end
		case (state)
			st_idle: begin
				if (start_wr) begin
					next_write_trigger = 1'b1;
					next_wr_addr = ee_address_reg;
					next_wr_data = ee_data_reg;
					next_timer = '0;
					next_state = st_write;
				end else if (start_rd) begin
					next_read_trigger = 1'b1;
					next_state = st_read;
				end
			end
			st_read: begin
				next_ee_data_reg = mem.rdata;
				next_read_trigger = 1'b0;
				next_state = st_idle;
			end
			st_write: begin
				// stand-in for the independent write timer
				if (timer == TIMER_W'(WRITE_LEN - 1)) begin
					next_timer_done = 1'b1;
					next_state = st_write_sync;
				end else begin
					next_timer = timer + TIMER_W'(1);
				end
			end
			st_write_sync: begin
				if (done_sync) begin
					next_write_trigger = 1'b0;
					irq_set[ST_EE_BIT] = 1'b1;
					irq_set[ST_MF_BIT] = 1'b1;
					next_state = st_idle;
				end
			end
			default: next_state = st_idle;
		endcase
		if (cpu_halt && (state != st_idle)) begin
			// halting mid-operation abandons it, no array update
			next_read_trigger = 1'b0;
			next_write_trigger = 1'b0;
			irq_set = '0;
			irq_set[ST_FAIL_BIT] = 1'b1;
			next_state = st_idle;
		end
	end

	// sticky status: set beats clear
	always_comb begin
		irq_clr = '0;
		if (bus_wr && (sel == sel_irq_status)) begin
			irq_clr = pwdata[IRQ_W-1:0];
		end
		if (irq_serviced) begin
			irq_clr[ST_MF_BIT] = 1'b1;
		end
		next_irq_status = (irq_status & ~irq_clr) | irq_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= st_idle;
			ee_address_reg <= '0;
			ee_data_reg <= '0;
			pointer_one_high_byte <= POINTER_HIGH_POR;
			pointer_two_high_byte <= POINTER_HIGH_POR;
			pointer_one_low_byte <= '0;
			pointer_two_low_byte <= '0;
			write_arm_bit <= 1'b0;
			write_trigger <= 1'b0;
			read_arm_bit <= 1'b0;
			read_trigger <= 1'b0;
			global_irq_enable <= 1'b0;
			irq_mask <= '0;
			irq_status <= '0;
			timer <= '0;
			timer_done <= 1'b0;
			done_meta <= 1'b0;
			done_sync <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			ready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			slverr_q <= 1'b0;
		end else begin
			state <= next_state;
			ee_address_reg <= next_ee_address_reg;
			ee_data_reg <= next_ee_data_reg;
			pointer_one_high_byte <= next_pointer_one_high_byte;
			pointer_two_high_byte <= next_pointer_two_high_byte;
			pointer_one_low_byte <= next_pointer_one_low_byte;
			pointer_two_low_byte <= next_pointer_two_low_byte;
			write_arm_bit <= next_write_arm_bit;
			write_trigger <= next_write_trigger;
			read_arm_bit <= next_read_arm_bit;
			read_trigger <= next_read_trigger;
			global_irq_enable <= next_global_irq_enable;
			irq_mask <= next_irq_mask;
			irq_status <= next_irq_status;
			timer <= next_timer;
			timer_done <= next_timer_done;
			done_meta <= timer_done;
			done_sync <= done_meta;
			wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
			ready_q <= next_ready_q;
			prdata_q <= next_prdata_q;
			slverr_q <= next_slverr_q;
		end
	end

	assign prdata = prdata_q;
	assign pready = ready_q;
	assign pslverr = slverr_q && ready_q;
	assign busy = (state != st_idle);
	assign irq = |(irq_status & irq_mask);
	assign mf_vector_request = global_irq_enable && irq_mask[ST_EE_BIT] &&
		irq_mask[ST_MF_BIT] && irq_status[ST_EE_BIT] && irq_status[ST_MF_BIT] &&
		!stack_full;
endmodule : eeprom_access_control

/* File: eeprom_access_control_props.sv */
`timescale 1ns/1ps
module eeprom_access_control_props
	import eeprom_access_pkg::*;
#(
	parameter int WRITE_LEN = WRITE_CYCLES
) (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic cpu_halt, // halt
	input wire logic stack_full, // stack full
	input wire logic irq_serviced, // vector taken
	input wire logic irq, // interrupt
	input wire logic mf_vector_request, // vector request
	input wire logic busy // operation running
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	int cnt;
	logic halted;
	// busy length and whether a halt hit the operation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			halted <= 1'b0;
		end else begin
			cnt <= busy ? cnt + 1 : 0;
			halted <= busy ? (halted | cpu_halt) : 1'b0;
		end
	end
	property p_ready_second; $rose(penable) && psel |-> !pready ##1 pready; endproperty
	a_ready_second: assert property (p_ready_second) else $error("ready not on second access");
	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
	property p_ready_access; pready |-> psel && penable; endproperty
	a_ready_access: assert property (p_ready_access) else $error("ready outside access");
	property p_err_ready; pslverr |-> pready; endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	property p_stack; stack_full |-> !mf_vector_request; endproperty
	a_stack: assert property (p_stack) else $error("vector while stack full");
	property p_vec_irq; mf_vector_request |-> irq; endproperty
	a_vec_irq: assert property (p_vec_irq) else $error("vector without interrupt");
	property p_busy_len; $fell(busy) && !halted |-> cnt == 1 || cnt == WRITE_LEN + 3; endproperty
	a_busy_len: assert property (p_busy_len) else $error("operation length wrong");
	property p_abort; busy && cpu_halt |-> ##[1:3] !busy; endproperty
	a_abort: assert property (p_abort) else $error("halt did not abort");
	property p_service; irq_serviced && mf_vector_request && !busy |=> !mf_vector_request; endproperty
	a_service: assert property (p_service) else $error("vector flag not cleared");
	c_write: cover property ($fell(busy) && cnt == WRITE_LEN + 3);
	c_read: cover property ($fell(busy) && cnt == 1);
	c_abort: cover property (busy && cpu_halt);
	c_vector: cover property (mf_vector_request && irq_serviced);
endmodule : eeprom_access_control_props
bind eeprom_access_control eeprom_access_control_props #(.WRITE_LEN(WRITE_LEN)) chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .cpu_halt(cpu_halt), .stack_full(stack_full),
	.irq_serviced(irq_serviced), .irq(irq), .mf_vector_request(mf_vector_request), .busy(busy)
);

/* File: core_model.sv */
`timescale 1ns/1ps
module core_model (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic mf_vector_request, // vector request
	input wire logic accept, // core willing to take vectors
	output logic irq_serviced // one-cycle vector taken
);
	// takes the vector once, clearing the multi-function flag
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_serviced <= 1'b0;
		else
			irq_serviced <= mf_vector_request && accept && !irq_serviced;
	end
endmodule : core_model

/* File: eeprom_access_control_test.sv */
`timescale 1ns/1ps
module eeprom_access_control_test;
	import eeprom_access_pkg::*;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, cpu_halt = 0, stack_full = 0, irq_serviced, irq, mfv, busy, e;
	logic accept = 0;
	int err_total = 0, tests_run = 0, cycles = 0;
	row_t rows [10] = '{
		'{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h0c, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h18, 32'h0, 32'h0, 1'b0},
		'{1'b1, 8'h00, 32'hff, 32'h0, 1'b0},
		'{1'b0, 8'h00, 32'h0, 32'h3f, 1'b0},
		'{1'b1, 8'h04, 32'h5a, 32'h0, 1'b0},
		'{1'b0, 8'h04, 32'h0, 32'h5a, 1'b0},
		'{1'b1, 8'h2c, 32'h1, 32'h0, 1'b1},
		'{1'b0, 8'h2c, 32'h0, 32'h0, 1'b1},
		'{1'b0, 8'h24, 32'h0, 32'h0, 1'b0}
	};
	eeprom_access_control #(.WRITE_LEN(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cpu_halt(cpu_halt), .stack_full(stack_full),
		.irq_serviced(irq_serviced), .irq(irq), .mf_vector_request(mfv), .busy(busy));
	core_model core (.pclk(pclk), .presetn(presetn), .mf_vector_request(mfv), .accept(accept),
		.irq_serviced(irq_serviced));
	initial begin
		forever #2 pclk = ~pclk;
	end
	task chk(input logic [31:0] got, input logic [31:0] x);
		tests_run++;
		if (got !== x) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, x);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so the next setup never reassigns psel in this step
		@(posedge pclk);
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask : rd
	task wait_idle;
		int n;
		n = 0;
		@(posedge pclk);
		while (busy !== 1'b0 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		chk(busy, 1'b0);
	endtask : wait_idle
	task give_verdict;
		$display("errors %0d of %0d checks", err_total, tests_run);
		if (err_total == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict
	always @(posedge pclk) begin
		cycles++;
		if (cycles > 5000) begin
			err_total++;
			give_verdict();
		end
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk(r, rows[i].x);
			chk(e, rows[i].e);
		end
		wr(OFS_PTR_ONE_HIGH, 32'h1);
		wr(OFS_PTR_ONE_LOW, 32'h40);
		rd(OFS_INDIRECT_ONE, 32'h0);
		wr(OFS_EE_ADDRESS, 32'h05);
		wr(OFS_IRQ_CTRL, 32'h0);
		wr(OFS_IRQ_MASK, 32'h3);
		stack_full <= 1'b1;
		wr(OFS_INDIRECT_ONE, 32'h08);
		wr(OFS_INDIRECT_ONE, 32'h0c);
		rd(OFS_INDIRECT_ONE, 32'h0c);
		wr(OFS_IRQ_CTRL, 32'h1);
		wait_idle();
		rd(OFS_INDIRECT_ONE, 32'h08);
		rd(OFS_IRQ_STATUS, 32'h3);
		chk(mfv, 1'b0);
		chk(irq, 1'b1);
		stack_full <= 1'b0;
		@(posedge pclk);
		chk(mfv, 1'b1);
		accept <= 1'b1;
		repeat (3) @(posedge pclk);
		rd(OFS_IRQ_STATUS, 32'h1);
		wr(OFS_IRQ_STATUS, 32'h1);
		rd(OFS_IRQ_STATUS, 32'h0);
		accept <= 1'b0;
		wr(OFS_EE_DATA, 32'h0);
		wr(OFS_INDIRECT_ONE, 32'h02);
		wr(OFS_INDIRECT_ONE, 32'h03);
		wait_idle();
		rd(OFS_INDIRECT_ONE, 32'h02);
		rd(OFS_EE_DATA, 32'h5a);
		wr(OFS_INDIRECT_ONE, 32'h00);
		wr(OFS_INDIRECT_ONE, 32'h0c);
		wait_idle();
		rd(OFS_IRQ_STATUS, 32'h0);
		wr(OFS_INDIRECT_ONE, 32'h01);
		chk(busy, 1'b0);
		wr(OFS_INDIRECT_ONE, 32'h08);
		wr(OFS_INDIRECT_ONE, 32'h0c);
		cpu_halt <= 1'b1;
		repeat (3) @(posedge pclk);
		cpu_halt <= 1'b0;
		wait_idle();
		rd(OFS_IRQ_STATUS, 32'h4);
		rd(OFS_INDIRECT_ONE, 32'h08);
		chk(irq, 1'b0);
		wr(OFS_IRQ_MASK, 32'h7);
		chk(irq, 1'b1);
		wr(OFS_IRQ_STATUS, 32'h7);
		chk(irq, 1'b0);
		// mid-run reset with write arm set and both high bytes nonzero
		wr(OFS_PTR_TWO_HIGH, 32'h1);
		wr(OFS_INDIRECT_ONE, 32'h08);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(prdata, 32'h0);
		chk(busy, 1'b0);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFS_PTR_ONE_HIGH, 32'h0);
		rd(OFS_PTR_TWO_HIGH, 32'h0);
		wr(OFS_PTR_ONE_HIGH, 32'h1);
		wr(OFS_PTR_ONE_LOW, 32'h40);
		rd(OFS_INDIRECT_ONE, 32'h0);
		give_verdict();
	end
endmodule : eeprom_access_control_test
